// ---- rtl/adc_control_status.sv ----
// Converter control and status register with trigger and bank control
`timescale 1ns/1ps
`include "adc_ctl_params.svh"
module adc_control_status
	import adc_ctl_pkg::*;
#(
	parameter int DEPTH = `BANK_DEPTH,
	parameter int DIO_W = 16
)(
	input  wire logic                      mclk,
	input  wire logic                      rst_b,
	input  wire logic [7:0]                addr,
	input  wire logic [3:0]                be,
	input  wire logic [31:0]               wdata,
	input  wire logic                      wr_stb,
	input  wire logic                      rd_stb,
	output logic [31:0]                    rdata,
	input  wire logic [$clog2(DEPTH)-1:0]  threshold,
	input  wire logic                      sample_wr,
	input  wire logic                      sw_trigger,
	input  wire logic                      mem_read,
	input  wire logic                      trig_out_b,
	input  wire logic [DIO_W-1:0]          dio_in,
	input  wire logic [DIO_W-1:0]          dio_dir_sw,
	input  wire logic [DIO_W-1:0]          dio_out_sw,
	output logic                           irq,
	output logic                           straight_bin,
	output logic [2:0]                     source_sel,
	output logic                           timer_en,
	output logic [2:0]                     scan_mode,
	output logic                           ext_trig_b,
	output logic                           read_bank,
	output logic [$clog2(DEPTH)-1:0]       wr_ptr,
	output logic [DIO_W-1:0]               dio_oe_b,
	output logic [DIO_W-1:0]               dio_out
);
	if (DEPTH != `BANK_DEPTH)
	begin : g_bad_depth
		$error("bank depth must be 512");
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] lanes);
		merge16 = old;
		if (lanes[0])
			merge16[7:0] = nw[7:0];
		if (lanes[1])
			merge16[15:8] = nw[15:8];
	endfunction : merge16

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	csr_t        csr_reg;
	csr_t        csr_next;
	logic        csr_hit;
	logic        bank_switch;
	logic        ext_trig_d_reg;
	logic        ext_trig_fall;
	logic        trig_event;
	logic [15:0] wr_val;

	assign csr_hit       = (addr == `CSR_OFFSET);
	assign ext_trig_fall = ext_trig_d_reg & ~ext_trig_b;
	assign trig_event    = sw_trigger | (ext_trig_fall && csr_reg.trig == TRIG_IN);
	assign wr_val        = merge16(csr_reg, wdata[15:0], be[1:0]); // RL1

	always_comb
	begin
		csr_next = csr_reg;
		if (wr_stb && csr_hit)
		begin
			csr_next                  = csr_t'(wr_val); // RL11
			csr_next.irq_pend         = csr_reg.irq_pend; // RL15
			csr_next.transition       = csr_reg.transition; // RL21
			if (be[1] && wdata[`BIT_IRQ_PEND])
				csr_next.irq_pend = 1'b0; // RL15
		end
		if (!csr_next.irq_en || mem_read)
			csr_next.irq_pend = 1'b0; // RL14
		if (mem_read)
			csr_next.transition = 1'b0; // RL19
		if (bank_switch)
		begin
			csr_next.transition = 1'b1; // RL18
			if (csr_next.irq_en)
				csr_next.irq_pend = 1'b1; // RL13
			if (csr_next.auto_stop)
				csr_next.scan = SCAN_STOP; // RL16
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			csr_reg <= csr_t'(`CSR_RESET); // RL2
		else
			csr_reg <= csr_next;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			ext_trig_d_reg <= 1'b1;
		else
			ext_trig_d_reg <= ext_trig_b;
	end

	// ----------------------------------------
	// Read port and outputs
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			rdata <= '0;
		else if (rd_stb && csr_hit)
			rdata <= {16'h0000, csr_reg}; // RL1
		else
			rdata <= '0;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq          <= 1'b0;
			straight_bin <= 1'b0;
			source_sel   <= 3'h0;
			timer_en     <= 1'b0;
			scan_mode    <= 3'h0;
		end
		else
		begin
			irq          <= csr_next.irq_pend; // RL13
			straight_bin <= csr_next.straight; // RL3
			source_sel   <= csr_next.source; // RL9
			timer_en     <= csr_next.timer_en; // RL10
			scan_mode    <= csr_next.scan; // RL12
		end
	end

	// ----------------------------------------
	// Sub-blocks
	// ----------------------------------------
	trig_route #(.DIO_W(DIO_W)) u_trig (
		.mclk       (mclk),
		.rst_b      (rst_b),
		.trig       (csr_reg.trig),
		.trig_out_b (trig_out_b),
		.dio_in     (dio_in),
		.dio_dir_sw (dio_dir_sw),
		.dio_out_sw (dio_out_sw),
		.ext_trig_b (ext_trig_b),
		.dio_oe_b   (dio_oe_b),
		.dio_out    (dio_out)
	);

	bank_ctl #(.DEPTH(DEPTH)) u_bank (
		.mclk        (mclk),
		.rst_b       (rst_b),
		.sample_wr   (sample_wr),
		.ptr_reset   (trig_event && !csr_reg.keep_ptr), // RL17
		.threshold   (threshold),
		.bank_switch (bank_switch),
		.read_bank   (read_bank),
		.wr_ptr      (wr_ptr)
	);
endmodule : adc_control_status

// ---- rtl/adc_ctl_params.svh ----
// Constants for the converter control and status block
// Overview of operation
// RL1 - Register takes byte, half and word accesses
// RL2 - Reset clears every control bit
// RL3 - Bit 0 picks two's complement or straight
// RL4 - Bits 2:1 disable, trigger in, or out
// RL5 - Input on channel 0, output on 8
// RL6 - Trigger output forces channels 8-15 output
// RL7 - Software sets channels 0-7 input for trigger
// RL8 - One module drives trigger, others input it
// RL9 - Bits 5:3 select input or calibration source
// RL10 - Bit 6 enables interval timer
// RL11 - Unused bit 7 reads back as written
// RL12 - Bits 10:8 select scan mode
// RL13 - Bit 11 enables threshold interrupt request
// RL14 - Request holds until memory read or disable
// RL15 - Bit 12 reads pending, write one releases
// RL16 - Bit 13 stops scan on bank switch
// RL17 - Bit 14 clear: trigger resets write pointer
// RL18 - Bit 15 sets on bank switch
// RL19 - First memory read clears bit 15
// RL20 - Two 512 banks switch past threshold
// RL21 - Writes to bit 15 are ignored
`ifndef ADC_CTL_PARAMS_SVH
`define ADC_CTL_PARAMS_SVH
`define CSR_OFFSET      8'h04
`define CSR_RESET       16'h0000
`define THRESH_RESET    9'h1ff
`define BANK_DEPTH      512
`define BIT_CODING      0
`define BIT_TRIG_LO     1
`define BIT_SRC_LO      3
`define BIT_TIMER       6
`define BIT_SPARE       7
`define BIT_SCAN_LO     8
`define BIT_IRQ_EN      11
`define BIT_IRQ_PEND    12
`define BIT_AUTO_STOP   13
`define BIT_KEEP_PTR    14
`define BIT_TRANSITION  15
`define DIO_TRIG_IN     0
`define DIO_TRIG_OUT    8
`endif

// ---- rtl/adc_ctl_pkg.sv ----
// Types for the converter control and status block
package adc_ctl_pkg;
	typedef enum logic [1:0] {TRIG_OFF = 2'h0, TRIG_IN = 2'h1, TRIG_OUT = 2'h2,
		TRIG_OFF2 = 2'h3} trig_mode_t;
	typedef enum logic [2:0] {SCAN_STOP = 3'h0, SCAN_UNI_CONT = 3'h1,
		SCAN_UNI_SINGLE = 3'h2, SCAN_BURST_CONT = 3'h3, SCAN_BURST_SINGLE = 3'h4,
		SCAN_TRIG_ONLY = 3'h5, SCAN_RSVD6 = 3'h6, SCAN_RSVD7 = 3'h7} scan_mode_t;
	typedef struct packed {
		logic        transition;
		logic        keep_ptr;
		logic        auto_stop;
		logic        irq_pend;
		logic        irq_en;
		scan_mode_t  scan;
		logic        spare;
		logic        timer_en;
		logic [2:0]  source;
		trig_mode_t  trig;
		logic        straight;
	} csr_t;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} bus_req_t;
endpackage : adc_ctl_pkg

// ---- rtl/bank_ctl.sv ----
// Ping-pong sample bank tracking
`timescale 1ns/1ps
`include "adc_ctl_params.svh"
module bank_ctl #(
	parameter int DEPTH = `BANK_DEPTH
)(
	input  wire logic                      mclk,
	input  wire logic                      rst_b,
	input  wire logic                      sample_wr,
	input  wire logic                      ptr_reset,
	input  wire logic [$clog2(DEPTH)-1:0]  threshold,
	output logic                           bank_switch,
	output logic                           read_bank,
	output logic [$clog2(DEPTH)-1:0]       wr_ptr
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_bad_depth
		$error("bank depth must be a power of two");
	end
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr      <= '0;
			read_bank   <= 1'b0;
			bank_switch <= 1'b0;
		end
		else
		begin
			bank_switch <= 1'b0;
			if (sample_wr && wr_ptr == threshold)
			begin
				wr_ptr      <= '0; // RL20
				read_bank   <= ~read_bank;
				bank_switch <= 1'b1;
			end
			else if (ptr_reset)
				wr_ptr <= '0;
			else if (sample_wr)
				wr_ptr <= wr_ptr + AW'(1);
		end
	end
endmodule : bank_ctl

// ---- rtl/trig_route.sv ----
// Trigger routing onto the digital channels
`timescale 1ns/1ps
`include "adc_ctl_params.svh"
module trig_route
	import adc_ctl_pkg::*;
#(
	parameter int DIO_W = 16
)(
	input  wire logic              mclk,
	input  wire logic              rst_b,
	input  wire trig_mode_t        trig,
	input  wire logic              trig_out_b,
	input  wire logic [DIO_W-1:0]  dio_in,
	input  wire logic [DIO_W-1:0]  dio_dir_sw,
	input  wire logic [DIO_W-1:0]  dio_out_sw,
	output logic                   ext_trig_b,
	output logic [DIO_W-1:0]       dio_oe_b,
	output logic [DIO_W-1:0]       dio_out
);
	if (DIO_W != 16)
	begin : g_bad_width
		$error("trig_route needs 16 channels");
	end
	logic [DIO_W-1:0] dir_next;
	logic [DIO_W-1:0] out_next;
	always_comb
	begin
		dir_next = dio_dir_sw;
		out_next = dio_out_sw;
		if (trig == TRIG_OUT)
		begin
			dir_next[15:8] = 8'hff; // RL6
			out_next[`DIO_TRIG_OUT] = trig_out_b; // RL5
		end
		if (trig == TRIG_IN)
			dir_next[`DIO_TRIG_IN] = 1'b0; // RL5
	end
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dio_oe_b   <= '1;
			dio_out    <= '0;
			ext_trig_b <= 1'b1;
		end
		else
		begin
			dio_oe_b   <= ~dir_next;
			dio_out    <= out_next;
			ext_trig_b <= (trig == TRIG_IN) ? dio_in[`DIO_TRIG_IN] : 1'b1; // RL4
		end
	end
endmodule : trig_route

// ---- tb/adc_control_status_properties.sv ----
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module adc_control_status_properties
	import adc_ctl_pkg::*;
#(
	parameter int DEPTH = 512,
	parameter int DIO_W = 16
)(
	input wire logic	mclk,
	input wire logic	rst_b,
	input wire logic [7:0]	addr,
	input wire logic [3:0]	be,
	input wire logic [31:0]	wdata,
	input wire logic	wr_stb,
	input wire logic	rd_stb,
	input wire logic [31:0]	rdata,
	input wire logic [$clog2(DEPTH)-1:0]	threshold,
	input wire logic	sample_wr,
	input wire logic	mem_read,
	input wire logic [DIO_W-1:0]	dio_in,
	input wire logic	irq,
	input wire logic [2:0]	scan_mode,
	input wire logic	ext_trig_b,
	input wire logic	read_bank,
	input wire logic [$clog2(DEPTH)-1:0]	wr_ptr,
	input wire logic [DIO_W-1:0]	dio_oe_b
);
	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	a_rdata_idle_zero: assert property (!rd_stb |=> rdata == 32'h0)
		else $error("rdata not idle");
	a_unmapped_read_zero: assert property (rd_stb && addr != 8'h04 |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	a_trig_out_group: assert property (wr_stb && addr == 8'h04 && be[0]
		&& wdata[2:1] == 2'h2 |-> ##[1:3] dio_oe_b[15:8] == 8'h00)
		else $error("group not forced out");
	a_bank_wrap: assert property (sample_wr && wr_ptr == threshold
		|=> wr_ptr == '0 && read_bank != $past(read_bank))
		else $error("bank did not switch");
	a_bank_hold: assert property (!sample_wr |=> $stable(read_bank))
		else $error("bank switched alone");
	a_irq_read_release: assert property (irq && mem_read && $stable(read_bank) |=> !irq)
		else $error("irq kept after read");
	a_scan_change_cause: assert property ($changed(scan_mode)
		|-> $past(wr_stb) || $past(read_bank) != $past(read_bank, 2))
		else $error("scan changed alone");
	a_trig_in_source: assert property (!ext_trig_b
		|-> !$past(dio_in[0]) || !$past(dio_in[0], 2))
		else $error("trigger not from channel 0");
	c_wrap: cover property (sample_wr && wr_ptr == threshold);
	c_irq: cover property ($rose(irq));
	c_trig: cover property ($fell(ext_trig_b));
endmodule : adc_control_status_properties
bind adc_control_status adc_control_status_properties #(.DEPTH(DEPTH), .DIO_W(DIO_W)) u_props (
	.mclk, .rst_b, .addr, .be, .wdata, .wr_stb, .rd_stb, .rdata, .threshold, .sample_wr,
	.mem_read, .dio_in, .irq, .scan_mode, .ext_trig_b, .read_bank, .wr_ptr, .dio_oe_b
);

// ---- tb/adc_control_status_test.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_control_status_test import adc_ctl_pkg::*;;
	// -------
	// Signals
	// -------
	logic	mclk = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, run = 1'b0, slow = 1'b0;
	logic	sw_trigger = 1'b0, mem_read = 1'b0, trig_out_b = 1'b1, sample_wr;
	logic	irq, straight_bin, timer_en, ext_trig_b, read_bank;
	logic [7:0]	addr = 8'h00;
	logic [3:0]	be = 4'h0;
	logic [31:0]	wdata = 32'h0, rdata, s = 32'h0001354c;
	logic [8:0]	threshold = 9'h003, wr_ptr;
	logic [15:0]	dio_in = 16'hffff, dio_dir_sw = 16'h0000, dio_out_sw = 16'h0000;
	logic [15:0]	dio_oe_b, dio_out;
	logic [2:0]	source_sel, scan_mode;
	int	m = 0, m_ptr = 0, m_bank = 0, fail_count = 0, compares = 0;
	always #10 mclk = ~mclk;
	adc_control_status dut (.mclk, .rst_b, .addr, .be, .wdata, .wr_stb, .rd_stb, .rdata,
		.threshold, .sample_wr, .sw_trigger, .mem_read, .trig_out_b, .dio_in, .dio_dir_sw,
		.dio_out_sw, .irq, .straight_bin, .source_sel, .timer_en, .scan_mode, .ext_trig_b,
		.read_bank, .wr_ptr, .dio_oe_b, .dio_out);
	sample_feeder u_feed (.mclk, .run, .slow, .sample_wr);
	always @(posedge mclk)
		if (rst_b && sample_wr)
			if (m_ptr == threshold)
			begin
				m_ptr = 0;
				m_bank ^= 1;
				m[15] = 1'b1;
				m[12] = m[12] | m[11];
				if (m[13])
					m[10:8] = 3'h0;
			end
			else
				m_ptr++;
	// -----
	// Tasks
	// -----
	function logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			$display("BAD %0t %h %h", $time, g, e);
			fail_count++;
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		logic [15:0] k;
		k = {{8{b[1]}}, {8{b[0]}}} & 16'h6fff;
		@(posedge mclk);
		addr <= a;
		be <= b;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
		if (a == 8'h04)
		begin
			m = (m & ~k) | (d[15:0] & k);
			if ((b[1] && d[12]) || !m[11])
				m[12] = 1'b0;
		end
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		@(negedge mclk);
		chk(rdata, e);
	endtask : rd
	task st();
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		chk({irq, read_bank, wr_ptr}, {m[12], m_bank[0], m_ptr[8:0]});
		rd(8'h04, m);
	endtask : st
	task feed(input int n);
		int b;
		b = m_bank;
		run <= 1'b1;
		slow <= (n == 0);
		repeat (n > 0 ? n : 40)
			if (m_bank == b || n > 0)
				@(posedge mclk);
		run <= 1'b0;
		st();
	endtask : feed
	task pulse(input logic t);
		@(posedge mclk);
		if (t)
			sw_trigger <= 1'b1;
		else
			mem_read <= 1'b1;
		@(posedge mclk);
		sw_trigger <= 1'b0;
		mem_read <= 1'b0;
	endtask : pulse
	task end_sim();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (4000) @(posedge mclk);
		fail_count++;
		end_sim();
	end
	// --------
	// Sequence
	// --------
	initial
	begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		@(negedge mclk);
		chk(dio_oe_b, 16'hffff);
		rd(8'h04, 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			s = nxt(s);
			wr(8'h04, i < 8 ? 4'h3 : s[19:16],
				{s[31:11], i[2:0], s[7], s[6] | (i[0] & ~i[2]), i[2:0], i[1:0], s[0]});
			dio_out_sw <= s[15:0];
			dio_dir_sw <= {s[31:24], (i[1:0] == 2'h1) ? 8'h00 : s[23:16]};
			rd(8'h04, m);
			chk({straight_bin, source_sel, timer_en, scan_mode}, {m[0], m[5:3], m[6], m[10:8]});
			chk(dio_oe_b, 16'(~(dio_dir_sw | (m[2:1] == 2'h2 ? 16'hff00 : 16'h0000))));
			chk(dio_out, {dio_out_sw[15:9], m[2:1] == 2'h2 ? trig_out_b : dio_out_sw[8],
				dio_out_sw[7:0]});
		end
		wr(8'h08, 4'hf, 32'hffffffff);
		dio_dir_sw <= 16'h0000;
		rd(8'h08, 32'h0);
		wr(8'h04, 4'h3, 32'h2);
		feed(2);
		@(posedge mclk);
		dio_in <= 16'hfffe;
		m_ptr = 0;
		st();
		chk(ext_trig_b, 1'b0);
		@(posedge mclk);
		dio_in <= 16'hffff;
		wr(8'h04, 4'h3, 32'h4000);
		feed(1);
		pulse(1'b1);
		st();
		wr(8'h04, 4'h3, 32'h0);
		pulse(1'b1);
		m_ptr = 0;
		st();
		wr(8'h04, 4'h1, 32'h4);
		trig_out_b <= 1'b0;
		repeat (3) @(posedge mclk);
		chk({dio_oe_b[15:8], dio_out[8]}, 9'h0);
		trig_out_b <= 1'b1;
		wr(8'h04, 4'h3, 32'h2941);
		feed(0);
		wr(8'h04, 4'h2, 32'ha800);
		rd(8'h04, m);
		pulse(1'b0);
		m[15] = 1'b0;
		m[12] = 1'b0;
		st();
		wr(8'h04, 4'h3, 32'h0941);
		feed(0);
		wr(8'h04, 4'h2, 32'h1900);
		st();
		feed(0);
		wr(8'h04, 4'h2, 32'h0100);
		st();
		end_sim();
	end
endmodule : adc_control_status_test

// ---- tb/sample_feeder.sv ----
// Sample write source for the converter control block
`timescale 1ns/1ps
module sample_feeder (
	input wire logic	mclk,
	input wire logic	run,
	input wire logic	slow,
	output logic	sample_wr
);
	// ------
	// Pacing
	// ------
	logic [1:0]	pace_reg = 2'h0;
	always @(posedge mclk)
	begin
		pace_reg <= pace_reg + 2'h1;
		sample_wr <= run && (!slow || pace_reg == 2'h0);
	end
endmodule : sample_feeder
